//--- rtl/tdmsp_top.sv
// TDM serial port line timing: transmit serialiser, receive link and domain crossings
//
// Notes on behaviour
// - Each transmit bit leaves on a rising edge of the transmit line clock.
// - Transmit clock may be gapped up to 52 MHz; bits go only on present edges.
// - Blocked or missing periods carry no new bit; rate stays at most 52 Mbps.
// - Outside X.86 mode the transmit data-enable input blocks or allows individual transmit bits.
// - Transmit data-enable active level is programmable by configuration.
// - In X.86 mode the shared pin drives out a pulse on each byte's last bit.
// - Byte marker is driven only in X.86 mode; otherwise the pin is an input.
// - Each receive bit is captured on a rising edge of the receive line clock.
// - Receive clock may be gapped up to 52 MHz; sampling only on present edges.
// - One receive marker fixes the byte boundary until a new marker arrives.
`timescale 1ns/1ns
`default_nettype none
module tdmsp_top
	import tdmsp_pkg::*;
(
	input  wire logic              CLOCK,
	input  wire logic              RST,
	input  wire logic              CE,
	input  wire logic              X86_MODE,
	input  wire logic              TX_ENABLE_ACTIVE_HIGH,
	input  wire logic              RX_ENABLE_ACTIVE_HIGH,
	input  wire logic [BYTE_W-1:0] TX_DATA,
	input  wire logic              TX_VALID,
	output logic                   TX_READY,
	output logic      [BYTE_W-1:0] RX_DATA,
	output logic                   RX_VALID,
	output logic                   RX_OVERRUN,
	input  wire logic              TX_LINE_CLOCK_IN,
	output logic                   TX_LINE_SERIAL_OUT,
	input  wire logic              TX_LINE_BIT_ENABLE,
	output logic                   TX_LINE_BYTE_MARKER,
	output logic                   TX_LINE_BYTE_MARKER_OE,
	input  wire logic              RX_LINE_CLOCK_IN,
	input  wire logic              RX_LINE_SERIAL_IN,
	input  wire logic              RX_LINE_BIT_ENABLE
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	tdmsp_sys_s            sys;
	tdmsp_sys_s            next_sys;
	tdmsp_tx_s             tx;
	tdmsp_tx_s             next_tx;
	logic [LNK_SYNC_W-1:0] tx_sync_in;
	logic [LNK_SYNC_W-1:0] tx_sync;
	logic [LNK_SYNC_W-1:0] rx_sync_in;
	logic [LNK_SYNC_W-1:0] rx_sync;
	logic [SYS_SYNC_W-1:0] sys_sync_in;
	logic [SYS_SYNC_W-1:0] sys_sync;
	logic [BYTE_W-1:0]     rx_hold;
	logic                  rx_req_tgl;
	logic                  rx_ovr_tgl;
	logic                  tx_rst;
	logic                  tx_ce;
	logic                  tx_x86;
	logic                  tx_pol;
	logic                  tx_req_sync;
	logic                  tx_accept;

	// ------------------------------------------------------------------
	// Crossings into the transmit line domain
	// ------------------------------------------------------------------

	// Reset, clock enable, mode and polarity are slow levels; the request is a toggle
	always_comb begin
		tx_sync_in          = '0;
		tx_sync_in[LNK_RST] = RST;
		tx_sync_in[LNK_CE]  = CE;
		tx_sync_in[LNK_X86] = X86_MODE;
		tx_sync_in[LNK_POL] = TX_ENABLE_ACTIVE_HIGH;
		tx_sync_in[LNK_TGL] = sys.tx_req_tgl;
	end

	tdmsp_sync3 #(
		.WIDTH (LNK_SYNC_W)
	) u_tx_sync (
		.clk (TX_LINE_CLOCK_IN),
		.d   (tx_sync_in),
		.q   (tx_sync)
	);

	assign tx_rst      = tx_sync[LNK_RST];
	assign tx_ce       = tx_sync[LNK_CE];
	assign tx_x86      = tx_sync[LNK_X86];
	assign tx_pol      = tx_sync[LNK_POL];
	assign tx_req_sync = tx_sync[LNK_TGL];

	// ------------------------------------------------------------------
	// Crossings into the receive line domain
	// ------------------------------------------------------------------

	// Same bundle shape as transmit; the toggle slot carries the acknowledge
	always_comb begin
		rx_sync_in          = '0;
		rx_sync_in[LNK_RST] = RST;
		rx_sync_in[LNK_CE]  = CE;
		rx_sync_in[LNK_X86] = X86_MODE;
		rx_sync_in[LNK_POL] = RX_ENABLE_ACTIVE_HIGH;
		rx_sync_in[LNK_TGL] = sys.rx_ack_tgl;
	end

	tdmsp_sync3 #(
		.WIDTH (LNK_SYNC_W)
	) u_rx_sync (
		.clk (RX_LINE_CLOCK_IN),
		.d   (rx_sync_in),
		.q   (rx_sync)
	);

	// ------------------------------------------------------------------
	// Crossings back into the system domain
	// ------------------------------------------------------------------

	// All three are toggles; each edge is one event
	always_comb begin
		sys_sync_in             = '0;
		sys_sync_in[SYS_TX_ACK] = tx.ack_tgl;
		sys_sync_in[SYS_RX_REQ] = rx_req_tgl;
		sys_sync_in[SYS_RX_OVR] = rx_ovr_tgl;
	end

	tdmsp_sync3 #(
		.WIDTH (SYS_SYNC_W)
	) u_sys_sync (
		.clk (CLOCK),
		.d   (sys_sync_in),
		.q   (sys_sync)
	);

	// ------------------------------------------------------------------
	// System domain: byte intake and receive hand-off
	// ------------------------------------------------------------------

	// One byte in flight toward the line; ready drops until the line takes it
	assign TX_READY  = !sys.tx_full;
	assign tx_accept = TX_VALID && !sys.tx_full;

	// The hold registers cross as buses: each stays still until its toggle is answered
	always_comb begin
		next_sys            = sys;
		next_sys.rx_valid   = 1'b0;
		next_sys.rx_overrun = 1'b0;
		// Line side answered: slot is free again
		if (sys_sync[SYS_TX_ACK] != sys.tx_ack_seen) begin
			next_sys.tx_ack_seen = sys_sync[SYS_TX_ACK];
			next_sys.tx_full     = 1'b0;
		end
		// New byte from the user; only when the slot was already free
		if (tx_accept) begin
			next_sys.tx_hold    = TX_DATA;
			next_sys.tx_full    = 1'b1;
			next_sys.tx_req_tgl = !sys.tx_req_tgl;
		end
		// Received byte waiting in the line domain
		if (sys_sync[SYS_RX_REQ] != sys.rx_req_seen) begin
			next_sys.rx_req_seen = sys_sync[SYS_RX_REQ];
			next_sys.rx_data     = rx_hold;
			next_sys.rx_valid    = 1'b1;
			next_sys.rx_ack_tgl  = !sys.rx_ack_tgl;
		end
		// Line domain dropped a byte because the previous one was still held
		if (sys_sync[SYS_RX_OVR] != sys.rx_ovr_seen) begin
			next_sys.rx_ovr_seen = sys_sync[SYS_RX_OVR];
			next_sys.rx_overrun  = 1'b1;
		end
	end

	// System state register, frozen while the clock enable is low
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			sys <= SYS_STATE_RESET;
		end else if (CE) begin
			sys <= next_sys;
		end
	end

	assign RX_DATA    = sys.rx_data;
	assign RX_VALID   = sys.rx_valid;
	assign RX_OVERRUN = sys.rx_overrun;

	// ------------------------------------------------------------------
	// Transmit line domain: serialiser
	// ------------------------------------------------------------------

	// Bits leave MSB first; an empty slot at a byte boundary sends idle fill
	always_comb begin
		logic launch;
		launch  = 1'b0;
		next_tx = tx;
		// Marker drive follows the mode; the pin is an input otherwise
		next_tx.marker_oe = tx_x86;
		// Take the pending byte once the request toggle is seen stable
		if (tx_req_sync != tx.req_seen && !tx.next_full) begin
			next_tx.req_seen  = tx_req_sync;
			next_tx.next_byte = sys.tx_hold;
			next_tx.next_full = 1'b1;
			next_tx.ack_tgl   = !tx.ack_tgl;
		end
		// Enable level was set up by the far side before this edge
		launch = tx_x86 || line_bit_active(TX_LINE_BIT_ENABLE, tx_pol);
		if (launch) begin
			next_tx.serial = tx.shift[BYTE_W-1];
			next_tx.marker = tx_x86 && (tx.bit_idx == LAST_BIT_IDX);
			if (tx.bit_idx == LAST_BIT_IDX) begin
				next_tx.bit_idx = FIRST_BIT_IDX;
				if (tx.next_full) begin
					next_tx.shift     = tx.next_byte;
					next_tx.next_full = 1'b0;
				end else begin
					next_tx.shift = TX_IDLE_FILL;
				end
			end else begin
				next_tx.bit_idx = bit_idx_step(tx.bit_idx);
				next_tx.shift   = {tx.shift[BYTE_W-2:0], 1'b0};
			end
		end else begin
			// Blocked period: line level, shifter and pointer all stand still
			next_tx.marker = 1'b0;
		end
	end

	// A gapped clock simply gives no edge, so no bit moves in a missing period
	always_ff @(posedge TX_LINE_CLOCK_IN) begin
		if (tx_rst) begin
			tx <= TX_STATE_RESET;
		end else if (tx_ce) begin
			tx <= next_tx;
		end
	end

	assign TX_LINE_SERIAL_OUT     = tx.serial;
	assign TX_LINE_BYTE_MARKER    = tx.marker;
	assign TX_LINE_BYTE_MARKER_OE = tx.marker_oe;

	// ------------------------------------------------------------------
	// Receive line domain
	// ------------------------------------------------------------------

	// Runs on the far side's receive clock; hands whole bytes back by toggle
	tdmsp_rx_link u_rx_link (
		.clk                (RX_LINE_CLOCK_IN),
		.rst                (rx_sync[LNK_RST]),
		.ce                 (rx_sync[LNK_CE]),
		.x86_mode           (rx_sync[LNK_X86]),
		.enable_active_high (rx_sync[LNK_POL]),
		.serial_in          (RX_LINE_SERIAL_IN),
		.bit_enable_pin     (RX_LINE_BIT_ENABLE),
		.ack_tgl            (rx_sync[LNK_TGL]),
		.hold               (rx_hold),
		.req_tgl            (rx_req_tgl),
		.ovr_tgl            (rx_ovr_tgl)
	);

	// ------------------------------------------------------------------
	// Timing notes and limitations for users of this block
	// ------------------------------------------------------------------

	// Both line clocks belong to the far side and may stop at any time.
	// Nothing in a line domain moves without an edge, so a stopped clock
	// also stops every crossing that needs that domain to answer.

	// Reset and clock enable reach each line domain through its own
	// synchroniser. The line clocks must therefore run while reset is held,
	// for at least five rising edges, or the line state stays unknown.

	// The transmit slot holds one byte. Ready stays low for the whole round
	// trip: about four present line edges and then about four system clocks.
	// This keeps the hold register still while the line domain copies it,
	// at the cost of throughput when the line clock is far slower.

	// After reset the shifter holds idle fill, so at least one idle byte goes
	// out before the first user byte. An empty slot at a byte boundary
	// sends a further idle byte rather than stalling the line.

	// The receive hold register is freed only when its acknowledge has
	// crossed back into the receive domain. A byte that completes before
	// that is dropped and reported as an overrun pulse. At full line rate
	// with a slow system clock this is expected and must be handled above.

	// In byte sync mode no receive byte is passed on until the first
	// marker has fixed the boundary; the count then runs modulo eight.
	// Outside that mode bytes are counted from reset with no boundary.

	// Mode and polarity inputs are static configuration. They cross as
	// plain levels, so they may change only while reset is held.

	// Each toggle carries exactly one event; there are no set and clear
	// flags, so an event and its acknowledge can never collide.


endmodule : tdmsp_top
`default_nettype wire

//--- rtl/tdmsp_pkg.sv
// Shared constants, state types and helpers of the TDM serial port timing block
package tdmsp_pkg;

	// ------------------------------------------------------------------
	// Widths and line constants
	// ------------------------------------------------------------------
	localparam int                   BYTE_W             = 8;
	localparam int                   BIT_IDX_W          = 3;
	localparam logic [BIT_IDX_W-1:0] FIRST_BIT_IDX      = 3'h0;
	localparam logic [BIT_IDX_W-1:0] LAST_BIT_IDX       = 3'h7;
	localparam logic [BYTE_W-1:0]    TX_IDLE_FILL       = 8'hFF;
	localparam logic [BYTE_W-1:0]    BYTE_RESET         = 8'h00;
	localparam logic                 SERIAL_IDLE        = 1'b1;
	localparam int                   LINE_CLOCK_MAX_MHZ = 52;
	localparam int                   SYS_CLOCK_MHZ      = 10;

	// ------------------------------------------------------------------
	// Bit positions inside the synchroniser bundles
	// ------------------------------------------------------------------
	localparam int LNK_SYNC_W  = 5;
	localparam int LNK_RST     = 0;
	localparam int LNK_CE      = 1;
	localparam int LNK_X86     = 2;
	localparam int LNK_POL     = 3;
	localparam int LNK_TGL     = 4;
	localparam int SYS_SYNC_W  = 3;
	localparam int SYS_TX_ACK  = 0;
	localparam int SYS_RX_REQ  = 1;
	localparam int SYS_RX_OVR  = 2;

	// ------------------------------------------------------------------
	// State of each clock domain
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [BYTE_W-1:0] tx_hold;
		logic              tx_full;
		logic              tx_req_tgl;
		logic              tx_ack_seen;
		logic [BYTE_W-1:0] rx_data;
		logic              rx_valid;
		logic              rx_ack_tgl;
		logic              rx_req_seen;
		logic              rx_ovr_seen;
		logic              rx_overrun;
	} tdmsp_sys_s;

	typedef struct packed {
		logic [BYTE_W-1:0]    shift;
		logic [BIT_IDX_W-1:0] bit_idx;
		logic [BYTE_W-1:0]    next_byte;
		logic                 next_full;
		logic                 req_seen;
		logic                 ack_tgl;
		logic                 serial;
		logic                 marker;
		logic                 marker_oe;
	} tdmsp_tx_s;

	typedef struct packed {
		logic [BYTE_W-1:0]    shift;
		logic [BIT_IDX_W-1:0] bit_idx;
		logic                 aligned;
		logic [BYTE_W-1:0]    hold;
		logic                 busy;
		logic                 req_tgl;
		logic                 ack_seen;
		logic                 ovr_tgl;
	} tdmsp_rx_s;

	localparam tdmsp_sys_s SYS_STATE_RESET = '0;
	localparam tdmsp_tx_s  TX_STATE_RESET  = '{shift: TX_IDLE_FILL, bit_idx: FIRST_BIT_IDX,
		next_byte: BYTE_RESET, next_full: 1'b0, req_seen: 1'b0, ack_tgl: 1'b0,
		serial: SERIAL_IDLE, marker: 1'b0, marker_oe: 1'b0};
	localparam tdmsp_rx_s  RX_STATE_RESET  = '0;

	// Data-enable pin decode against its programmed active level
	function automatic logic line_bit_active(input logic pin, input logic active_high);
		return pin == active_high;
	endfunction : line_bit_active

	// Bit pointer step, wraps after the last bit of a byte
	function automatic logic [BIT_IDX_W-1:0] bit_idx_step(input logic [BIT_IDX_W-1:0] idx);
		return BIT_IDX_W'(idx + 3'h1);
	endfunction : bit_idx_step

endpackage : tdmsp_pkg

//--- rtl/tdmsp_sync3.sv
// Three-stage synchroniser with agreement filter for a bundle of levels
`timescale 1ns/1ns
`default_nettype none
module tdmsp_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} tdmsp_sync_s;

	tdmsp_sync_s st;
	tdmsp_sync_s next_st;

	// Stage one feeds stage two only; output follows once stages two and three agree
	always_comb begin
		next_st    = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.out[i] = st.s3[i];
			end
		end
	end

	// No reset here: the reset itself travels through this block
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign q = st.out;

endmodule : tdmsp_sync3
`default_nettype wire

//--- rtl/tdmsp_rx_link.sv
// Receive side of the serial line, clocked by the far side's receive clock
`timescale 1ns/1ns
`default_nettype none
module tdmsp_rx_link
	import tdmsp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic              x86_mode,
	input  wire logic              enable_active_high,
	input  wire logic              serial_in,
	input  wire logic              bit_enable_pin,
	input  wire logic              ack_tgl,
	output logic      [BYTE_W-1:0] hold,
	output logic                   req_tgl,
	output logic                   ovr_tgl
);

	tdmsp_rx_s st;
	tdmsp_rx_s next_st;

	// ------------------------------------------------------------------
	// Bit capture, byte assembly and hand-off
	// ------------------------------------------------------------------
	always_comb begin
		logic                 active;
		logic                 resync;
		logic [BIT_IDX_W-1:0] pos;
		logic                 free;
		active  = 1'b0;
		resync  = 1'b0;
		pos     = FIRST_BIT_IDX;
		free    = 1'b0;
		next_st = st;
		// Returned acknowledge frees the hold register
		if (ack_tgl != st.ack_seen) begin
			next_st.ack_seen = ack_tgl;
			next_st.busy     = 1'b0;
		end
		free = !st.busy || (ack_tgl != st.ack_seen);
		// Enable is sampled with the very bit it qualifies
		active = x86_mode || line_bit_active(bit_enable_pin, enable_active_high);
		resync = x86_mode && bit_enable_pin;
		if (active) begin
			pos               = resync ? FIRST_BIT_IDX : st.bit_idx;
			next_st.aligned   = st.aligned || resync;
			next_st.shift     = {st.shift[BYTE_W-2:0], serial_in};
			next_st.bit_idx   = bit_idx_step(pos);
			// Until the first marker in X.86 mode no boundary is known
			if (pos == LAST_BIT_IDX && (next_st.aligned || !x86_mode)) begin
				if (free) begin
					next_st.hold    = {st.shift[BYTE_W-2:0], serial_in};
					next_st.busy    = 1'b1;
					next_st.req_tgl = !st.req_tgl;
				end else begin
					next_st.ovr_tgl = !st.ovr_tgl;
				end
			end
		end
	end

	// Only edges that the far side really gives move this logic
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= RX_STATE_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign hold    = st.hold;
	assign req_tgl = st.req_tgl;
	assign ovr_tgl = st.ovr_tgl;

endmodule : tdmsp_rx_link
`default_nettype wire

//--- sim/tdmsp_checker.sv
// Port-level assertions for the TDM serial port timing block
`timescale 1ns/1ns
`default_nettype none
module tdmsp_checker (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic X86_MODE,
	input wire logic TX_ENABLE_ACTIVE_HIGH,
	input wire logic TX_VALID,
	input wire logic TX_READY,
	input wire logic RX_VALID,
	input wire logic TX_LINE_CLOCK_IN,
	input wire logic TX_LINE_SERIAL_OUT,
	input wire logic TX_LINE_BIT_ENABLE,
	input wire logic TX_LINE_BYTE_MARKER,
	input wire logic TX_LINE_BYTE_MARKER_OE
);
	// ------------------------------------------------------------------
	// Transmit line domain
	// ------------------------------------------------------------------
	// A blocked edge must leave the line exactly as it was
	a_tx_blocked_hold: assert property (
		@(posedge TX_LINE_CLOCK_IN) disable iff (RST)
		!X86_MODE && (TX_LINE_BIT_ENABLE != TX_ENABLE_ACTIVE_HIGH) |=> $stable(TX_LINE_SERIAL_OUT))
		else $error("serial line moved on a blocked edge");
	a_marker_only_x86: assert property (
		@(posedge TX_LINE_CLOCK_IN) disable iff (RST)
		TX_LINE_BYTE_MARKER |-> TX_LINE_BYTE_MARKER_OE && X86_MODE)
		else $error("byte marker outside byte sync mode");
	a_pin_stays_input: assert property (
		@(posedge TX_LINE_CLOCK_IN) disable iff (RST)
		!X86_MODE |-> !TX_LINE_BYTE_MARKER_OE)
		else $error("shared pin driven outside byte sync mode");
	a_marker_one_bit: assert property (
		@(posedge TX_LINE_CLOCK_IN) disable iff (RST)
		TX_LINE_BYTE_MARKER |=> !TX_LINE_BYTE_MARKER [*7])
		else $error("byte marker closer than one byte");
	// Every present edge launches in byte sync mode, so markers are 8 edges apart
	a_marker_period: assert property (
		@(posedge TX_LINE_CLOCK_IN) disable iff (RST)
		TX_LINE_BYTE_MARKER |-> ##8 TX_LINE_BYTE_MARKER)
		else $error("byte marker missing after eight edges");
	// ------------------------------------------------------------------
	// System domain
	// ------------------------------------------------------------------
	// The handover must cross both ways before another byte is taken
	a_ready_drops: assert property (
		@(posedge CLOCK) disable iff (RST)
		TX_VALID && TX_READY |=> !TX_READY [*4])
		else $error("transmit ready returned too early");
	a_ready_returns: assert property (
		@(posedge CLOCK) disable iff (RST)
		TX_VALID && TX_READY |-> ##[1:400] TX_READY)
		else $error("transmit ready never returned");
	a_rx_single_pulse: assert property (
		@(posedge CLOCK) disable iff (RST)
		RX_VALID |=> !RX_VALID)
		else $error("receive valid longer than one cycle");
endmodule : tdmsp_checker

bind tdmsp_top tdmsp_checker i_chk (.CLOCK(CLOCK), .RST(RST), .X86_MODE(X86_MODE),
	.TX_ENABLE_ACTIVE_HIGH(TX_ENABLE_ACTIVE_HIGH), .TX_VALID(TX_VALID),
	.TX_READY(TX_READY), .RX_VALID(RX_VALID), .TX_LINE_CLOCK_IN(TX_LINE_CLOCK_IN),
	.TX_LINE_SERIAL_OUT(TX_LINE_SERIAL_OUT), .TX_LINE_BIT_ENABLE(TX_LINE_BIT_ENABLE),
	.TX_LINE_BYTE_MARKER(TX_LINE_BYTE_MARKER),
	.TX_LINE_BYTE_MARKER_OE(TX_LINE_BYTE_MARKER_OE));
`default_nettype wire

//--- sim/tdmsp_far_end.sv
// Behavioural framer on the far side of the serial line
`timescale 1ns/1ns
`default_nettype none
module tdmsp_far_end (
	input  wire logic rst,
	input  wire logic x86,
	input  wire logic tpol,
	input  wire logic rpol,
	output logic      tx_clk,
	output logic      tx_en,
	input  wire logic tx_ser,
	input  wire logic tx_mk,
	output logic      rx_clk,
	output logic      rx_ser,
	output logic      rx_en
);
	logic       launch = 1'b0;
	logic [2:0] cnt = 3'h0;
	logic [7:0] sh;
	logic       early = 1'b0;
	logic [7:0] got_byte;
	logic [1:0] got_mk;
	event       got_ev;

	// ------------------------------------------------------------------
	// Transmit clock, gapped at random but free running in reset
	// ------------------------------------------------------------------
	initial begin
		tx_clk = 1'b0;
		tx_en = 1'b0;
		rx_clk = 1'b0;
		rx_ser = 1'b1;
		rx_en = 1'b0;
		forever begin
			#40;
			if (rst || $urandom_range(3) != 0) tx_clk = 1'b1;
			#40;
			tx_clk = 1'b0;
		end
	end

	// Enable is set up just after the edge before the bit it qualifies
	always @(posedge tx_clk) begin
		launch <= x86 || (tx_en == tpol);
		tx_en <= rst ? 1'b1 : 1'($urandom_range(1));
	end

	// Framing: user bytes have a clear top bit, idle fill is all ones
	always @(negedge tx_clk) begin
		if (rst) begin
			cnt = 3'h0;
			early = 1'b0;
		end else if (launch && (cnt != 3'h0 || tx_ser === 1'b0)) begin
			sh = {sh[6:0], tx_ser};
			if (cnt == 3'h7) begin
				got_byte = sh;
				got_mk = {tx_mk, early};
				early = 1'b0;
				->got_ev;
			end else begin
				early = early | (tx_mk === 1'b1);
			end
			cnt = cnt + 3'h1;
		end
	end

	// ------------------------------------------------------------------
	// Receive side: clock runs only inside frames and idle stretches
	// ------------------------------------------------------------------
	task automatic rx_edge();
		#40 rx_clk = 1'b1;
		#40 rx_clk = 1'b0;
	endtask : rx_edge

	// Edges that carry nothing: enable inactive, no byte marker
	task automatic rx_idle(input int n);
		rx_en = x86 ? 1'b0 : ~rpol;
		repeat (n) rx_edge();
	endtask : rx_idle

	// One byte MSB first, blocked edges sprinkled in outside byte sync mode
	task automatic send_rx(input logic [7:0] b, input logic mark);
		for (int i = 7; i >= 0; i--) begin
			while (!x86 && $urandom_range(2) == 0) begin
				rx_en = ~rpol;
				rx_ser = 1'($urandom_range(1));
				rx_edge();
			end
			rx_ser = b[i];
			rx_en = x86 ? (mark && i == 7) : rpol;
			rx_edge();
		end
		// Released line shows the inverse, not a stale bit
		rx_ser = ~rx_ser;
		rx_en = x86 ? 1'b0 : ~rpol;
	endtask : send_rx
endmodule : tdmsp_far_end
`default_nettype wire

//--- sim/tb_tdm_serial_port_timing.sv
// Self-checking testbench of the TDM serial port timing block
`timescale 1ns/1ns
`default_nettype none
module tb_tdm_serial_port_timing;
	import tdmsp_pkg::*;
	logic              clock = 1'b0;
	logic              rst = 1'b1;
	logic              x86 = 1'b0;
	logic              tpol = 1'b1;
	logic              rpol = 1'b1;
	logic [BYTE_W-1:0] tx_data = 8'h00;
	logic              tx_valid = 1'b0;
	logic              tx_ready, rx_valid, rx_ovr, tclk, ten, tx_line_serial_out, tmk, tmk_oe;
	logic              rclk, rx_line_serial_in, ren;
	logic [BYTE_W-1:0] rx_data;
	logic [7:0]        txq[$];
	logic [7:0]        rxq[$];
	int                err_total = 0;
	int                cmp_count = 0;

	always #50 clock = ~clock;

	tdmsp_top i_dut (.CLOCK(clock), .RST(rst), .CE(1'b1), .X86_MODE(x86),
		.TX_ENABLE_ACTIVE_HIGH(tpol), .RX_ENABLE_ACTIVE_HIGH(rpol), .TX_DATA(tx_data),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid),
		.RX_OVERRUN(rx_ovr), .TX_LINE_CLOCK_IN(tclk), .TX_LINE_SERIAL_OUT(tx_line_serial_out),
		.TX_LINE_BIT_ENABLE(tmk_oe ? tmk : ten), .TX_LINE_BYTE_MARKER(tmk),
		.TX_LINE_BYTE_MARKER_OE(tmk_oe), .RX_LINE_CLOCK_IN(rclk),
		.RX_LINE_SERIAL_IN(rx_line_serial_in), .RX_LINE_BIT_ENABLE(ren));

	tdmsp_far_end i_far (.rst(rst), .x86(x86), .tpol(tpol), .rpol(rpol), .tx_clk(tclk),
		.tx_en(ten), .tx_ser(tx_line_serial_out), .tx_mk(tmk), .rx_clk(rclk), .rx_ser(rx_line_serial_in), .rx_en(ren));

	// ------------------------------------------------------------------
	// Checking and verdict
	// ------------------------------------------------------------------
	task automatic check(input string n, input logic [9:0] e, input logic [9:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : check

	task automatic conclude();
		if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude

	// Bytes seen on the transmit line, oldest note first
	always @(i_far.got_ev) begin
		check("tx_byte", txq.size() ? txq.pop_front() : 10'h3FF, i_far.got_byte);
		check("tx_marker", {x86, 1'b0}, i_far.got_mk);
	end

	// Received bytes, sampled mid-cycle so the valid pulse has settled
	always @(negedge clock) begin
		if (rx_valid === 1'b1)
			check("rx_byte", rxq.size() ? rxq.pop_front() : 10'h3FF, rx_data);
		if (!rst && rx_ovr !== 1'b0) check("rx_overrun", 10'h0, rx_ovr);
	end

	// ------------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------------
	task automatic send_tx(input logic [7:0] b);
		@(posedge clock);
		tx_valid <= 1'b1;
		tx_data <= b;
		do @(negedge clock); while (tx_ready !== 1'b1);
		@(posedge clock);
		txq.push_back(b);
		tx_valid <= 1'b0;
	endtask : send_tx

	// One mode: reset with line clocks running, then both directions at once
	task automatic run_mode(input logic m, input logic tp, input logic rp);
		logic [7:0] b;
		rst <= 1'b1;
		x86 <= m;
		tpol <= tp;
		rpol <= rp;
		fork
			repeat (8) @(posedge clock);
			i_far.rx_idle(6);
		join
		rst <= 1'b0;
		i_far.rx_idle(6);
		fork
			for (int i = 0; i < 12; i++) begin
				b = (i == 0) ? 8'h7F : (i == 1) ? 8'h00 : 8'($urandom_range(127));
				send_tx(b);
			end
			for (int j = 0; j < 12; j++) begin
				rxq.push_back(8'($urandom_range(255)));
				i_far.send_rx(rxq[rxq.size() - 1], j == 0);
				repeat (12) @(posedge clock);
			end
		join
		repeat (200) @(posedge clock);
		check("tx_left", 10'h0, 10'(txq.size()));
		check("rx_left", 10'h0, 10'(rxq.size()));
	endtask : run_mode

	// Both line modes, both enable polarities each way
	initial begin
		void'($urandom(33657));
		for (int k = 0; k < 4; k++)
			run_mode(k[1], k[0], ~k[0]);
		conclude();
	end

	// Watchdog well beyond four modes of traffic
	initial begin
		#3000000;
		err_total++;
		conclude();
	end
endmodule : tb_tdm_serial_port_timing
`default_nettype wire
